/* File: hdl/sbalu_pkg.sv */
// Package: types and constants of the subtract-with-borrow datapath slice
package sbalu_pkg;

   localparam int SBALU_DATA_W = 8;
   localparam int SBALU_MSB = 7;
   localparam int SBALU_NIB_W = 4;
   localparam logic [7:0] SBALU_ACC_RST = 8'h00;
   localparam logic SBALU_FLAG_RST = 1'b0;
   localparam int SBALU_LATENCY = 1;

   typedef enum logic [1:0] {
      SBALU_OP_NONE,
      SBALU_OP_TO_ACC,
      SBALU_OP_TO_MEM
   } sbalu_op_t;

   // Status flags kept by the slice
   typedef struct packed {
      logic signed_range_flag;
      logic null_result_flag;
      logic half_byte_carry;
      logic borrow_inverse_flag;
   } sbalu_flags_t;

   // One executed instruction request
   typedef struct packed {
      logic valid;
      sbalu_op_t op;
      logic [7:0] mem_data;
   } sbalu_req_t;

   // Memory write-back
   typedef struct packed {
      logic wr_en;
      logic [7:0] wr_data;
   } sbalu_memwr_t;

   localparam sbalu_flags_t SBALU_FLAGS_RST = '{SBALU_FLAG_RST, SBALU_FLAG_RST,
                                                SBALU_FLAG_RST, SBALU_FLAG_RST};

endpackage : sbalu_pkg

/* File: hdl/sbalu_top.sv */
// Module: subtract-with-borrow datapath slice with accumulator and flags
`timescale 1ns/10ps
module sbalu_top
   import sbalu_pkg::*;
(
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic SYS_RST_IN,
   // Instruction request from decode
   input wire sbalu_req_t REQ_IN,
   // Accumulator load from other instructions
   input wire logic ACC_LOAD_IN,
   input wire logic [7:0] ACC_LOAD_DATA_IN,
   // Flag load, e.g. status register writes
   input wire logic FLAGS_LOAD_IN,
   input wire sbalu_flags_t FLAGS_LOAD_DATA_IN,
   // State and write-back
   output sbalu_memwr_t MEM_WR_OUT,
   output logic [7:0] ACC_OUT,
   output sbalu_flags_t FLAGS_OUT
);

   // ==========================================================
   // Subtractor
   logic borrow_in;
   logic [8:0] diff_full;
   logic [4:0] diff_nib;
   logic [7:0] diff;
   logic exec;

   logic [7:0] acc_q, acc_d;
   sbalu_flags_t flags_q, flags_d;
   sbalu_memwr_t memwr_q, memwr_d;

   // Opcode decode shared by the datapath and its checks
   function automatic logic is_sub_op(input sbalu_op_t op);
      return (op == SBALU_OP_TO_ACC) || (op == SBALU_OP_TO_MEM);
   endfunction

   assign exec = REQ_IN.valid && is_sub_op(REQ_IN.op);
   assign borrow_in = ~flags_q.borrow_inverse_flag;
   // Ninth bit is the borrow out of the eight-bit difference
   assign diff_full = {1'b0, acc_q} - {1'b0, REQ_IN.mem_data} - {8'h00, borrow_in};
   assign diff_nib = {1'b0, acc_q[3:0]} - {1'b0, REQ_IN.mem_data[3:0]} - {4'h0, borrow_in};
   assign diff = diff_full[7:0];

   // ==========================================================
   // Next state
   always_comb begin
      acc_d = acc_q;
      flags_d = flags_q;
      memwr_d = '{1'b0, memwr_q.wr_data};
      if (exec) begin
         flags_d.borrow_inverse_flag = ~diff_full[8];
         flags_d.null_result_flag = (diff == 8'h00);
         flags_d.half_byte_carry = ~diff_nib[4];
         // Signs of operands differ and result sign differs from minuend
         flags_d.signed_range_flag = (acc_q[SBALU_MSB] ^ REQ_IN.mem_data[SBALU_MSB])
                                   & (acc_q[SBALU_MSB] ^ diff[SBALU_MSB]);
         if (REQ_IN.op == SBALU_OP_TO_ACC) begin
            acc_d = diff;
         end else begin
            memwr_d = '{1'b1, diff};
         end
      end else begin
         // Executing instruction takes priority over outside loads
         if (ACC_LOAD_IN) begin
            acc_d = ACC_LOAD_DATA_IN;
         end
         if (FLAGS_LOAD_IN) begin
            flags_d = FLAGS_LOAD_DATA_IN;
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         acc_q <= SBALU_ACC_RST;
         flags_q <= SBALU_FLAGS_RST;
         memwr_q <= '{1'b0, 8'h00};
      end else begin
         acc_q <= acc_d;
         flags_q <= flags_d;
         memwr_q <= memwr_d;
      end
   end

   assign ACC_OUT = acc_q;
   assign FLAGS_OUT = flags_q;
   assign MEM_WR_OUT = memwr_q;

   // ==========================================================
   // Assertions
   sequence s_exec_acc;
      REQ_IN.valid && REQ_IN.op == SBALU_OP_TO_ACC;
   endsequence

   sequence s_exec_mem;
      REQ_IN.valid && REQ_IN.op == SBALU_OP_TO_MEM;
   endsequence

   sequence s_idle;
      !exec && !ACC_LOAD_IN && !FLAGS_LOAD_IN;
   endsequence

   a_acc_result: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      s_exec_acc |=> acc_q == 8'($past(acc_q) - $past(REQ_IN.mem_data)
                     - {7'h00, ~$past(flags_q.borrow_inverse_flag)}))
      else $error("accumulator difference wrong");

   a_borrow_in_used: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (s_exec_acc and (acc_q == REQ_IN.mem_data) and flags_q.borrow_inverse_flag)
      |=> acc_q == 8'h00 && flags_q.borrow_inverse_flag)
      else $error("borrow-in not the inverse flag");

   a_borrow_clears: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      exec && ({1'b0, acc_q} < ({1'b0, REQ_IN.mem_data} + {8'h00, borrow_in}))
      |=> !flags_q.borrow_inverse_flag)
      else $error("borrow did not clear flag");

   a_noborrow_sets: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      exec && ({1'b0, acc_q} >= ({1'b0, REQ_IN.mem_data} + {8'h00, borrow_in}))
      |=> flags_q.borrow_inverse_flag)
      else $error("no borrow did not set flag");

   a_mem_write: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      s_exec_mem |=> MEM_WR_OUT.wr_en && $stable(acc_q)
                     && MEM_WR_OUT.wr_data == 8'($past(acc_q) - $past(REQ_IN.mem_data)
                     - {7'h00, ~$past(flags_q.borrow_inverse_flag)}))
      else $error("memory write-back wrong");

   a_mem_only: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      MEM_WR_OUT.wr_en |-> $past(REQ_IN.valid && REQ_IN.op == SBALU_OP_TO_MEM))
      else $error("spurious memory write");

   a_zero_flag: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      s_exec_acc |=> flags_q.null_result_flag == (acc_q == 8'h00))
      else $error("zero flag wrong");

   a_range_flag: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      exec && acc_q == 8'h80 && REQ_IN.mem_data == 8'h01 |=> flags_q.signed_range_flag)
      else $error("overflow flag not set");

   a_nibble_flag: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      exec && (acc_q[3:0] == 4'h0) && (REQ_IN.mem_data[3:0] != 4'h0)
      |=> !flags_q.half_byte_carry)
      else $error("nibble borrow missed");

   a_msb_borrow: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      exec && acc_q == 8'h00 && (REQ_IN.mem_data != 8'h00 || borrow_in)
      |=> !flags_q.borrow_inverse_flag)
      else $error("eight-bit borrow wrong");

   // ==========================================================
   // Write-back pulse and hold
   a_wr_one_cycle: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      MEM_WR_OUT.wr_en && !(REQ_IN.valid && REQ_IN.op == SBALU_OP_TO_MEM)
      |=> !MEM_WR_OUT.wr_en)
      else $error("write pulse too long");

   a_wr_data_hold: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      !exec |=> $stable(MEM_WR_OUT.wr_data))
      else $error("write data not held");

   a_acc_no_write: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      s_exec_acc |=> !MEM_WR_OUT.wr_en)
      else $error("accumulator variant wrote memory");

   // Loads must not sneak past a memory-variant execution
   a_mem_load_lost: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      s_exec_mem and ACC_LOAD_IN |=> $stable(acc_q))
      else $error("load overrode memory variant");

   // ==========================================================
   // Idle, loads and reset
   a_idle_hold: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      s_idle |=> $stable(acc_q) && $stable(flags_q))
      else $error("state moved while idle");

   a_acc_load: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      !exec && ACC_LOAD_IN |=> acc_q == $past(ACC_LOAD_DATA_IN))
      else $error("accumulator load lost");

   a_flags_load: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      !exec && FLAGS_LOAD_IN |=> flags_q == $past(FLAGS_LOAD_DATA_IN))
      else $error("flag load lost");

   a_reset_state: assert property (@(posedge CLK_IN)
      SYS_RST_IN |=> acc_q == SBALU_ACC_RST && flags_q == SBALU_FLAGS_RST
                     && !MEM_WR_OUT.wr_en && MEM_WR_OUT.wr_data == 8'h00)
      else $error("reset state wrong");

   // ==========================================================
   // Further flag checks
   a_nibble_clear: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      exec && acc_q[3:0] == 4'hf && !borrow_in |=> flags_q.half_byte_carry)
      else $error("false nibble borrow");

   // Equal signs can never leave the signed range
   a_range_quiet: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      exec && acc_q[SBALU_MSB] == REQ_IN.mem_data[SBALU_MSB] |=> !flags_q.signed_range_flag)
      else $error("false overflow");

   a_mem_zero_flag: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      s_exec_mem |=> flags_q.null_result_flag == (MEM_WR_OUT.wr_data == 8'h00))
      else $error("zero flag wrong on memory variant");

endmodule // sbalu_top

/* File: test/sbalu_top_test.sv */
// Testbench of the subtract-with-borrow datapath slice
`timescale 1ns/10ps
module sbalu_top_test;
   import sbalu_pkg::*;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   sbalu_req_t req_in = '0;
   logic acc_load_in = 1'b0;
   logic [7:0] acc_load_data_in = 8'h00;
   logic flags_load_in = 1'b0;
   sbalu_flags_t flags_load_data_in = '0;
   sbalu_memwr_t mem_wr_out;
   logic [7:0] acc_out;
   sbalu_flags_t flags_out;
   logic [11:0] e1;
   logic [11:0] e2;
   int error_cnt = 0;
   int compares = 0;
   // Row: to-memory, borrow-inverse flag, accumulator, memory byte
   logic [17:0] rows [8] = '{18'h10503, 18'h00503, 18'h00000, 18'h10000,
                             18'h18001, 18'h37fff, 18'h21001, 18'h2ffff};
   always #4 clk_in = ~clk_in;
   sbalu_top u_dut (.CLK_IN(clk_in), .SYS_RST_IN(sys_rst_in), .REQ_IN(req_in),
      .ACC_LOAD_IN(acc_load_in), .ACC_LOAD_DATA_IN(acc_load_data_in),
      .FLAGS_LOAD_IN(flags_load_in), .FLAGS_LOAD_DATA_IN(flags_load_data_in),
      .MEM_WR_OUT(mem_wr_out), .ACC_OUT(acc_out), .FLAGS_OUT(flags_out));
   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask
   // Flags in port order, then the eight-bit difference
   function automatic logic [11:0] model(input logic [7:0] a, input logic [7:0] m, input logic c);
      logic [8:0] d;
      logic [4:0] n;
      d = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
      n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
      return {(a[7] ^ m[7]) & (d[7] ^ a[7]), d[7:0] == 8'h00, ~n[4], ~d[8], d[7:0]};
   endfunction
   task automatic run(input logic to_mem, input logic c, input logic [7:0] a, input logic [7:0] m);
      logic [11:0] e;
      e = model(a, m, c);
      @(posedge clk_in);
      acc_load_in <= 1'b1;
      acc_load_data_in <= a;
      flags_load_in <= 1'b1;
      flags_load_data_in <= {3'h0, c};
      @(posedge clk_in);
      acc_load_in <= 1'b0;
      flags_load_in <= 1'b0;
      req_in <= '{1'b1, to_mem ? SBALU_OP_TO_MEM : SBALU_OP_TO_ACC, m};
      @(posedge clk_in);
      req_in <= '0;
      #1;
      if (to_mem) begin
         check("mem flags acc", {flags_out, acc_out}, {e[11:8], a});
         check("mem write", 12'(mem_wr_out), {3'h1, e[7:0]});
         @(posedge clk_in);
         #1;
         check("mem pulse", 12'(mem_wr_out.wr_en), 12'h000);
      end else begin
         check("acc flags", {flags_out, acc_out}, e);
         check("acc no write", 12'(mem_wr_out.wr_en), 12'h000);
      end
   endtask
   task automatic give_verdict();
      if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #5000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      #1;
      check("reset", {flags_out, acc_out}, 12'h000);
      check("reset write", 12'(mem_wr_out), 12'h000);
      for (int i = 0; i < 8; i++) run(rows[i][17], rows[i][16], rows[i][15:8], rows[i][7:0]);
      // Back to back with loads held high: loads must lose to execution
      e1 = model(8'h00, 8'h01, 1'b1);
      e2 = model(e1[7:0], 8'h01, e1[8]);
      @(posedge clk_in);
      acc_load_in <= 1'b1;
      acc_load_data_in <= 8'h00;
      flags_load_in <= 1'b1;
      flags_load_data_in <= 4'h1;
      @(posedge clk_in);
      req_in <= '{1'b1, SBALU_OP_TO_ACC, 8'h01};
      acc_load_data_in <= 8'h55;
      flags_load_data_in <= 4'he;
      repeat (2) @(posedge clk_in);
      req_in <= '{1'b1, SBALU_OP_NONE, 8'h01};
      acc_load_in <= 1'b0;
      flags_load_in <= 1'b0;
      #1;
      check("chained", {flags_out, acc_out}, e2);
      @(posedge clk_in);
      #1;
      check("no op", {flags_out, acc_out}, e2);
      give_verdict();
   end
endmodule // sbalu_top_test
